// File: core/amr_monitor_reference_control.sv
/*
 * Monitor/reference control register of a sensor converter, with the
 * serial port that reaches it and the override logic it drives.
 * Assumes serial pins, clock status and start come from outside mclk;
 * conversion busy, system gain and channel selections are mclk logic.
 */
`timescale 1ns/100ps
`default_nettype none
`include "amr_defines.svh"

module amr_monitor_reference_control
    import amr_pkg::*;
(
    // Clock and reset
    input  wire logic      mclk,
    input  wire logic      rst_b,
    // Serial port pins
    input  wire logic      spi_cs_b,
    input  wire logic      spi_sclk,
    input  wire logic      spi_din,
    output logic           spi_dout,
    output logic           spi_dout_oe,
    // Device status pins and signals
    input  wire logic      ext_clk_active,
    input  wire logic      start_pin,
    input  wire logic      conv_busy,
    // Neighbouring register fields
    input  wire amr_chan_type chan_in,
    input  wire logic [2:0]   sys_gain_code,
    // Analog front end controls
    output amr_chan_type    chan_out,
    output logic            ain_connect,
    output amr_mon_type     node_src,
    output amr_refpath_type refpath,
    output logic            int_ref_power,
    output logic [2:0]      pga_gain_code,
    output logic [7:0]      pga_gain_mult
);

    // Synchronised pins
    logic [4:0] sync_d;
    logic [4:0] sync_q;
    logic       cs_b_s;
    logic       sclk_s;
    logic       din_s;
    logic       ext_clk_s;
    logic       start_s;

    // Serial engine state
    amr_spi_state_type st_q;
    logic              sclk_prev_q;
    logic [2:0]        bit_cnt_q;
    logic [7:0]        rx_q;
    logic [7:0]        tx_q;
    logic [3:0]        addr_q;
    logic [3:0]        left_q;
    logic [7:0]        rx_byte;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              byte_done;
    logic              cmd_is_wr_q;

    // Register fields
    amr_pwr_type       pwr_ctl_q;
    amr_ref_type       ref_sel_q;
    amr_mon_type       mon_sel_q;
    logic              ref_auto_on_q;
    logic              sleep_cmd;
    logic              reset_cmd;
    logic              wr_hit;

    // Read value of an address: only the control register is mapped
    function automatic logic [7:0] read_reg(
        input logic [3:0]  a,
        input logic        clk_flag,
        input amr_pwr_type p,
        input amr_ref_type r,
        input amr_mon_type m
    );
        logic [7:0] v;
        v = `AMR_UNMAPPED_READ;
        if (a == `AMR_MRC_OFFSET) begin
            v = {clk_flag, p, r, m};
        end
        return v;
    endfunction

    // True for monitor codes that force unity gain
    function automatic logic gain_forced(input amr_mon_type m);
        return (m != AMR_MON_NORMAL) && (m != AMR_MON_MIDSUP);
    endfunction

    // Power-of-two gain from a three-bit code
    function automatic logic [7:0] gain_mult(input logic [2:0] c);
        return 8'h01 << c;
    endfunction

    // Pin synchronisers
    assign sync_d = {start_pin, ext_clk_active, spi_din, spi_sclk, spi_cs_b};

    amr_sync2 #(
        .WIDTH   (5),
        .RST_VAL (`AMR_SYNC_RESET)
    ) u_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .d     (sync_d),
        .q     (sync_q)
    );

    assign cs_b_s    = sync_q[0];
    assign sclk_s    = sync_q[1];
    assign din_s     = sync_q[2];
    assign ext_clk_s = sync_q[3];
    assign start_s   = sync_q[4];

    // Edges of the serial clock, taken after synchronisation
    assign sclk_rise = !cs_b_s && sclk_s && !sclk_prev_q;
    assign sclk_fall = !cs_b_s && !sclk_s && sclk_prev_q;
    assign byte_done = sclk_fall && (bit_cnt_q == 3'h7);
    assign rx_byte   = {rx_q[6:0], din_s};

    // Command decode on the first byte; control register write hit on a data byte
    assign sleep_cmd = byte_done && (st_q == AMR_ST_CMD) &&
                       (rx_byte[7:1] == `AMR_CMD_SLEEP);
    assign reset_cmd = byte_done && (st_q == AMR_ST_CMD) &&
                       (rx_byte[7:1] == `AMR_CMD_RESET);
    assign wr_hit    = byte_done && (st_q == AMR_ST_WR) &&
                       (addr_q == `AMR_MRC_OFFSET);

    // Serial clock history
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end

    // Bit counter and receive shifter; chip select high aborts a byte
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_q <= 3'h0;
            rx_q      <= 8'h00;
        end else if (cs_b_s) begin
            bit_cnt_q <= 3'h0;
        end else if (sclk_fall) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_q      <= rx_byte;
        end
    end

    // Transaction sequencer: command, count, then data bytes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q   <= AMR_ST_CMD;
            addr_q <= 4'h0;
            left_q <= 4'h0;
        end else if (cs_b_s) begin
            st_q <= AMR_ST_CMD;
        end else if (byte_done) begin
            unique case (st_q)
                AMR_ST_CMD: begin
                    addr_q <= rx_byte[3:0];
                    if (rx_byte[7:4] == `AMR_CMD_RREG ||
                        rx_byte[7:4] == `AMR_CMD_WREG) begin
                        st_q <= AMR_ST_CNT;
                    end
                end
                AMR_ST_CNT: begin
                    left_q <= rx_byte[3:0];
                    st_q   <= cmd_is_wr_q ? AMR_ST_WR : AMR_ST_RD;
                end
                AMR_ST_WR, AMR_ST_RD: begin
                    addr_q <= addr_q + 4'h1;
                    left_q <= left_q - 4'h1;
                    if (left_q == 4'h0) begin
                        st_q <= AMR_ST_CMD; // Next byte is a new command
                    end
                end
            endcase
        end
    end

    // Direction of the command, kept until the count byte is through
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_is_wr_q <= 1'b0;
        end else if (byte_done && st_q == AMR_ST_CMD) begin
            cmd_is_wr_q <= (rx_byte[7:4] == `AMR_CMD_WREG);
        end
    end

    // Transmit shifter: loaded at each read byte boundary, shifted on rise
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tx_q <= 8'h00;
        end else if (byte_done && st_q == AMR_ST_CNT && !cmd_is_wr_q) begin
            tx_q <= read_reg(addr_q, ext_clk_s, pwr_ctl_q, ref_sel_q,
                             mon_sel_q);
        end else if (byte_done && st_q == AMR_ST_RD) begin
            tx_q <= read_reg(addr_q + 4'h1, ext_clk_s, pwr_ctl_q,
                             ref_sel_q, mon_sel_q);
        end else if (sclk_rise && st_q == AMR_ST_RD) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // Data out pin: driven only while selected
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            spi_dout    <= 1'b0;
            spi_dout_oe <= 1'b0;
        end else begin
            spi_dout_oe <= !cs_b_s;
            if (cs_b_s) begin
                spi_dout <= 1'b0;
            end else if (sclk_rise && st_q == AMR_ST_RD) begin
                spi_dout <= tx_q[7];
            end
        end
    end

    // Control register fields; bit 7 of a write is dropped
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pwr_ctl_q <= AMR_PWR_OFF;
            ref_sel_q <= AMR_REF_PAIR0;
            mon_sel_q <= AMR_MON_NORMAL;
        end else if (reset_cmd) begin
            pwr_ctl_q <= AMR_PWR_OFF;
            ref_sel_q <= AMR_REF_PAIR0;
            mon_sel_q <= AMR_MON_NORMAL;
        end else if (wr_hit) begin
            pwr_ctl_q <= amr_pwr_type'(rx_byte[`AMR_MRC_PWR_MSB:
                                               `AMR_MRC_PWR_LSB]);
            ref_sel_q <= amr_ref_type'(rx_byte[`AMR_MRC_SEL_MSB:
                                               `AMR_MRC_SEL_LSB]);
            mon_sel_q <= amr_mon_type'(rx_byte[`AMR_MRC_MON_MSB:
                                               `AMR_MRC_MON_LSB]);
        end
    end

    // Follow-the-device reference state; off wins over a new conversion
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ref_auto_on_q <= 1'b0;
        end else begin
            if (sleep_cmd || !start_s) begin
                ref_auto_on_q <= 1'b0;
            end else if (conv_busy) begin
                ref_auto_on_q <= 1'b1;
            end
        end
    end

    // Reference power output
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            int_ref_power <= 1'b0;
        end else begin
            unique case (pwr_ctl_q)
                AMR_PWR_OFF:   int_ref_power <= 1'b0;
                AMR_PWR_ON:    int_ref_power <= 1'b1;
                AMR_PWR_AUTO,
                AMR_PWR_AUTO2: int_ref_power <= ref_auto_on_q;
            endcase
        end
    end

    // Reference switches; reference monitors pick their own pair
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            refpath <= '0;
        end else begin
            refpath <= '0;
            if (mon_sel_q == AMR_MON_REF1) begin
                refpath.use_pair1 <= 1'b1;
            end else if (mon_sel_q == AMR_MON_REF0) begin
                refpath.use_pair0 <= 1'b1;
            end else begin
                unique case (ref_sel_q)
                    AMR_REF_PAIR0: refpath.use_pair0 <= 1'b1;
                    AMR_REF_PAIR1: refpath.use_pair1 <= 1'b1;
                    AMR_REF_INT:   refpath.use_internal <= 1'b1;
                    AMR_REF_INT_DRIVE: begin
                        refpath.use_internal <= 1'b1;
                        refpath.drive_pair0  <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Converter node source; channels and bias only pass in normal mode
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            node_src    <= AMR_MON_NORMAL;
            ain_connect <= 1'b0;
            chan_out    <= '0;
        end else begin
            node_src <= mon_sel_q;
            if (mon_sel_q == AMR_MON_NORMAL) begin
                ain_connect <= 1'b1;
                chan_out    <= chan_in;
            end else begin
                ain_connect <= 1'b0;
                chan_out    <= '0;
            end
        end
    end

    // Amplifier gain; system field is read live so it returns by itself
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pga_gain_code <= 3'h0;
            pga_gain_mult <= 8'h01;
        end else if (gain_forced(mon_sel_q)) begin
            pga_gain_code <= 3'h0;
            pga_gain_mult <= gain_mult(3'h0);
        end else begin
            pga_gain_code <= sys_gain_code;
            pga_gain_mult <= gain_mult(sys_gain_code);
        end
    end

endmodule

`default_nettype wire

// File: core/amr_defines.svh
/*
 * Constants of the monitor/reference control block: register offset,
 * field positions, reset values and serial command codes.
 * Assumes inclusion by bare name from every core file that needs them.
 */
// Contract
// - Control register at 02h resets writable fields to zero; bit 7 follows clock.
// - Read-only bit 7 reads 0 for internal oscillator, 1 for external clock.
// - Reference power code 00 keeps reference off; 01 keeps it on.
// - Codes 10/11 power reference during conversion; off on sleep or start low.
// - Reference select: 00 pair0, 01 pair1, 10 internal, 11 internal driving pair0.
// - Non-normal monitor code overrides channels and bias enables; 100 and 101 also override reference select.
// - Monitor 000 is normal; 001 disconnects inputs, ties nodes to mid-supply.
// - Monitor 010 connects converter inputs across the selected reference.
// - Monitor 011 connects converter inputs to the temperature diode.
// - Monitor 100 applies pair1 reference over four; 101 pair0 over four.
// - Monitor 110 applies analog supply over four; 111 digital supply over four.
// - Monitor 010 to 111 force gain 1; 000 and 001 use system gain.
// - Returning to 000 or 001 restores system gain without rewriting it.
// - Gain field is three bits, powers of two from 1 to 128.
`ifndef AMR_DEFINES_SVH
`define AMR_DEFINES_SVH

// Register map
`define AMR_MRC_OFFSET      4'h2
`define AMR_MRC_CLK_BIT     7
`define AMR_MRC_PWR_MSB     6
`define AMR_MRC_PWR_LSB     5
`define AMR_MRC_SEL_MSB     4
`define AMR_MRC_SEL_LSB     3
`define AMR_MRC_MON_MSB     2
`define AMR_MRC_MON_LSB     0
`define AMR_MRC_RESET       7'h00
`define AMR_UNMAPPED_READ   8'h00

// Serial command codes (upper bits of the first byte)
`define AMR_CMD_RREG        4'h2
`define AMR_CMD_WREG        4'h4
`define AMR_CMD_SLEEP       7'h01
`define AMR_CMD_RESET       7'h03

// Synchroniser reset levels: chip select idle high, others low
`define AMR_SYNC_RESET      5'h01

`endif

// File: core/amr_pkg.sv
/*
 * Types of the monitor/reference control block: modes, states and the
 * packed carriers that pass between the block and the analog front end.
 * Assumes amr_defines.svh supplies the numeric constants.
 */
package amr_pkg;

    // Internal reference power control codes
    typedef enum logic [1:0] {
        AMR_PWR_OFF   = 2'b00,
        AMR_PWR_ON    = 2'b01,
        AMR_PWR_AUTO  = 2'b10,
        AMR_PWR_AUTO2 = 2'b11
    } amr_pwr_type;

    // Reference input selection codes
    typedef enum logic [1:0] {
        AMR_REF_PAIR0     = 2'b00,
        AMR_REF_PAIR1     = 2'b01,
        AMR_REF_INT       = 2'b10,
        AMR_REF_INT_DRIVE = 2'b11
    } amr_ref_type;

    // Monitor select codes: what the converter nodes see
    typedef enum logic [2:0] {
        AMR_MON_NORMAL  = 3'b000,
        AMR_MON_MIDSUP  = 3'b001,
        AMR_MON_FULLSC  = 3'b010,
        AMR_MON_TEMP    = 3'b011,
        AMR_MON_REF1    = 3'b100,
        AMR_MON_REF0    = 3'b101,
        AMR_MON_AVDD    = 3'b110,
        AMR_MON_DVDD    = 3'b111
    } amr_mon_type;

    // Serial port transaction states
    typedef enum logic [1:0] {
        AMR_ST_CMD = 2'b00,
        AMR_ST_CNT = 2'b01,
        AMR_ST_WR  = 2'b10,
        AMR_ST_RD  = 2'b11
    } amr_spi_state_type;

    // Channel and bias selections from the neighbouring registers
    typedef struct packed {
        logic [2:0] pos_ch;
        logic [2:0] neg_ch;
        logic [7:0] bias_en;
    } amr_chan_type;

    // Reference switch controls
    typedef struct packed {
        logic use_pair0;
        logic use_pair1;
        logic use_internal;
        logic drive_pair0;
    } amr_refpath_type;

endpackage

// File: core/amr_sync2.sv
/*
 * Two-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a level that stays stable for several mclk cycles.
 */
`timescale 1ns/100ps
`default_nettype none

module amr_sync2 #(
    parameter int                WIDTH   = 1,
    parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_b,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

`default_nettype wire

// File: tb/amr_mrc_asserts.sv
/*
 * Port checker for the monitor/reference control block.
 * Assumes a bind from the bench top and a single mclk domain.
 */
`timescale 1ns/100ps
`default_nettype none

module amr_mrc_asserts
    import amr_pkg::*;
(
    // Clock and reset
    input wire logic            mclk,
    input wire logic            rst_b,
    // Serial port
    input wire logic            spi_cs_b,
    input wire logic            spi_sclk,
    input wire logic            spi_din,
    input wire logic            spi_dout,
    input wire logic            spi_dout_oe,
    // Status levels
    input wire logic            ext_clk_active,
    input wire logic            start_pin,
    input wire logic            conv_busy,
    // Fields in, front end controls out
    input wire amr_chan_type    chan_in,
    input wire logic [2:0]      sys_gain_code,
    input wire amr_chan_type    chan_out,
    input wire logic            ain_connect,
    input wire amr_mon_type     node_src,
    input wire amr_refpath_type refpath,
    input wire logic            int_ref_power,
    input wire logic [2:0]      pga_gain_code,
    input wire logic [7:0]      pga_gain_mult
);

    // One domain, so clock and reset are stated once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    chk_gain_forced: assert property (
        node_src inside {[3'h2:3'h7]} |-> pga_gain_code == 3'h0
    ) else $error("gain not forced to unity in monitor mode");

    // Gain follows the system field with one register of delay
    chk_gain_restore: assert property (
        $past(rst_b) && node_src inside {3'h0, 3'h1}
        |-> pga_gain_code == $past(sys_gain_code)
    ) else $error("gain does not follow system gain field");

    chk_gain_mult: assert property (
        pga_gain_mult == (8'h01 << pga_gain_code)
    ) else $error("gain multiplier does not match gain code");

    chk_chan_override: assert property (
        node_src != AMR_MON_NORMAL |-> chan_out == 14'h0 && !ain_connect
    ) else $error("monitor code did not override channel selection");

    chk_chan_pass: assert property (
        $past(rst_b) && node_src == AMR_MON_NORMAL
        |-> chan_out == $past(chan_in) && ain_connect
    ) else $error("normal mode does not pass channel selection");

    chk_ref_mon0: assert property (
        node_src == AMR_MON_REF0 |-> refpath.use_pair0
    ) else $error("pair 0 monitor without pair 0 reference");

    chk_ref_mon1: assert property (
        node_src == AMR_MON_REF1 |-> refpath.use_pair1
    ) else $error("pair 1 monitor without pair 1 reference");

    // Exactly one reference source once reset has settled
    chk_ref_onehot: assert property (
        $past(rst_b) |-> $onehot({refpath.use_pair0, refpath.use_pair1,
                                  refpath.use_internal})
    ) else $error("reference selection not exactly one source");

endmodule

`default_nettype wire

// File: tb/amr_host_model.sv
/*
 * Host side of the serial port: frames, bytes and register calls.
 * Assumes the caller enters every task just after an mclk rising edge.
 */
`timescale 1ns/100ps
`default_nettype none

module amr_host_model (
    // Clock
    input  wire logic mclk,
    // Serial pins toward the device
    output logic      spi_cs_b,
    output logic      spi_sclk,
    output logic      spi_din,
    input  wire logic spi_dout
);

    // Idle: deselected, serial clock parked low
    initial begin
        spi_cs_b = 1'b1;
        spi_sclk = 1'b0;
        spi_din  = 1'b0;
    end

    // One byte MSB first; 4 mclk per phase covers the 2FF sync
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            #1 spi_sclk = 1'b1;
            spi_din = tx[i];
            repeat (4) @(posedge mclk);
            #1 rx[i] = spi_dout;
            spi_sclk = 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask

    // Whole frame; din has no pull, so it shows the inverse when released
    task automatic send(input logic [23:0] seq, input int nbytes,
                        output logic [7:0] rx);
        @(posedge mclk);
        #1 spi_cs_b = 1'b0;
        repeat (4) @(posedge mclk);
        for (int k = 0; k < nbytes; k++) begin
            xfer(seq[23 - 8 * k -: 8], rx);
        end
        #1 spi_cs_b = 1'b1;
        spi_din = ~spi_din;
        repeat (6) @(posedge mclk);
    endtask

    task automatic wr_reg(input logic [3:0] addr, input logic [7:0] data);
        logic [7:0] rx;
        send({4'h4, addr, 8'h00, data}, 3, rx);
    endtask

    task automatic rd_reg(input logic [3:0] addr, output logic [7:0] data);
        send({4'h2, addr, 8'h00, 8'hFF}, 3, data);
    endtask

    task automatic command(input logic [7:0] code);
        logic [7:0] rx;
        send({code, 16'h0000}, 1, rx);
    endtask

endmodule

`default_nettype wire

// File: tb/testbench.sv
/*
 * Self-checking bench for the monitor/reference control block.
 * Assumes the host model speaks the serial port and the checker is bound.
 */
`timescale 1ns/100ps
`default_nettype none

`define AMR_CHK(nm, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
        end \
    end

module testbench
    import amr_pkg::*;
;
    logic            mclk, rst_b, cs_b, sclk, din, dout, dout_oe;
    logic            ext_clk, start, busy, ain_conn, ref_pwr;
    amr_chan_type    chan_in, chan_out;
    amr_mon_type     node_src;
    amr_refpath_type refpath;
    logic [2:0]      sys_gain, gain_code, m;
    logic [3:0]      ref_exp [4] = '{4'h8, 4'h4, 4'h2, 4'h3};
    logic [7:0]      gain_mult, rd;
    int              num_errors, compares;
    int              mons [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 1, 0};

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    amr_monitor_reference_control i_dut (
        .mclk(mclk), .rst_b(rst_b), .spi_cs_b(cs_b), .spi_sclk(sclk),
        .spi_din(din), .spi_dout(dout), .spi_dout_oe(dout_oe),
        .ext_clk_active(ext_clk), .start_pin(start), .conv_busy(busy),
        .chan_in(chan_in), .sys_gain_code(sys_gain), .chan_out(chan_out),
        .ain_connect(ain_conn), .node_src(node_src), .refpath(refpath),
        .int_ref_power(ref_pwr), .pga_gain_code(gain_code),
        .pga_gain_mult(gain_mult)
    );

    amr_host_model i_host (
        .mclk(mclk), .spi_cs_b(cs_b), .spi_sclk(sclk), .spi_din(din),
        .spi_dout(dout)
    );

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Level change just after an edge, then time for the 2FF
    task automatic set_lvl(ref logic sig, input logic v);
        @(posedge mclk);
        #1 sig = v;
        repeat (5) @(posedge mclk);
    endtask

    // Hang guard: the sequence needs about 6k cycles
    initial begin
        repeat (80000) @(posedge mclk);
        num_errors++;
        $display("watchdog expired");
        tally_and_finish;
    end

    initial begin
        rst_b    = 1'b0;
        ext_clk  = 1'b0;
        start    = 1'b1;
        busy     = 1'b0;
        chan_in  = '{3'h5, 3'h2, 8'hA5};
        sys_gain = 3'h0;
        repeat (4) @(posedge mclk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge mclk);

        // Reset state
        i_host.rd_reg(4'h2, rd);
        `AMR_CHK("reset_value", 8'h00, rd)
        `AMR_CHK("reset_ain", 1'b1, ain_conn)
        `AMR_CHK("reset_mult", 8'h01, gain_mult)
        `AMR_CHK("idle_oe", 1'b0, dout_oe)
        $display("test reset done");

        // Clock flag follows the clock, never the written value
        set_lvl(ext_clk, 1'b1);
        i_host.wr_reg(4'h2, 8'h00);
        i_host.rd_reg(4'h2, rd);
        `AMR_CHK("clk_ext", 8'h80, rd)
        set_lvl(ext_clk, 1'b0);
        i_host.wr_reg(4'h2, 8'hFF);
        i_host.rd_reg(4'h2, rd);
        `AMR_CHK("clk_wr_ignored", 8'h7F, rd)
        $display("test clock flag done");

        // Every reference select code, reference powered on
        for (int r = 0; r < 4; r++) begin
            i_host.wr_reg(4'h2, {3'b001, 2'(r), 3'h0});
            `AMR_CHK("refpath", ref_exp[r], refpath)
        end
        $display("test reference select done");

        // Monitor codes, reference on first; ends back on 001 and 000
        #1 sys_gain = 3'h5;
        i_host.wr_reg(4'h2, 8'h20);
        foreach (mons[j]) begin
            m = 3'(mons[j]);
            i_host.wr_reg(4'h2, {3'b001, 2'b00, m});
            `AMR_CHK("node_src", m, node_src)
            `AMR_CHK("chan_out", m ? 14'h0 : chan_in, chan_out)
            `AMR_CHK("ain", m == 3'h0, ain_conn)
            `AMR_CHK("gain", m[2:1] ? 3'h0 : 3'h5, gain_code)
            if (m == 3'h4)
                `AMR_CHK("ref_mon1", 1'b1, refpath.use_pair1)
        end
        $display("test monitor codes done");

        // Gain field decoding in normal mode
        for (int g = 0; g < 8; g++) begin
            @(posedge mclk);
            #1 sys_gain = 3'(g);
            repeat (3) @(posedge mclk);
            `AMR_CHK("gain_mult", 8'h01 << g, gain_mult)
        end
        $display("test gain table done");

        // Reference power codes
        i_host.wr_reg(4'h2, 8'h00);
        `AMR_CHK("pwr_off", 1'b0, ref_pwr)
        i_host.wr_reg(4'h2, 8'h20);
        `AMR_CHK("pwr_on", 1'b1, ref_pwr)
        i_host.wr_reg(4'h2, 8'h40);
        set_lvl(busy, 1'b1);
        `AMR_CHK("auto_busy", 1'b1, ref_pwr)
        set_lvl(busy, 1'b0);
        set_lvl(start, 1'b0);
        `AMR_CHK("auto_start_low", 1'b0, ref_pwr)
        set_lvl(start, 1'b1);
        set_lvl(busy, 1'b1);
        set_lvl(busy, 1'b0);
        i_host.command(8'h02);
        `AMR_CHK("auto_sleep", 1'b0, ref_pwr)
        i_host.wr_reg(4'h2, 8'h60);
        set_lvl(busy, 1'b1);
        `AMR_CHK("auto11_busy", 1'b1, ref_pwr)
        set_lvl(busy, 1'b0);
        $display("test reference power done");

        // Unmapped address, then the reset command
        i_host.wr_reg(4'h2, 8'h2B);
        i_host.rd_reg(4'h3, rd);
        `AMR_CHK("unmapped_rd", 8'h00, rd)
        i_host.wr_reg(4'h3, 8'hFF);
        i_host.rd_reg(4'h2, rd);
        `AMR_CHK("unmapped_wr", 8'h2B, rd)
        i_host.command(8'h06);
        i_host.rd_reg(4'h2, rd);
        `AMR_CHK("reset_cmd", 8'h00, rd)
        $display("test unmapped and reset done");

        tally_and_finish;
    end

endmodule

bind amr_monitor_reference_control amr_mrc_asserts i_chk (
    .mclk(mclk), .rst_b(rst_b), .spi_cs_b(spi_cs_b), .spi_sclk(spi_sclk),
    .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe),
    .ext_clk_active(ext_clk_active), .start_pin(start_pin),
    .conv_busy(conv_busy), .chan_in(chan_in),
    .sys_gain_code(sys_gain_code), .chan_out(chan_out),
    .ain_connect(ain_connect), .node_src(node_src), .refpath(refpath),
    .int_ref_power(int_ref_power), .pga_gain_code(pga_gain_code),
    .pga_gain_mult(pga_gain_mult)
);

`default_nettype wire
